// *** design/cvtrim_pkg.sv ***
// constants shared by the converter trim and swap delay register bank
// assumes one 20 mhz clock, synchronous active-low reset, apb register access
package cvtrim_pkg;

    // =====================================================================
    // bus geometry
    // =====================================================================
    localparam int unsigned APB_AW   = 12;      // byte address width
    localparam int unsigned APB_DW   = 32;      // apb data width
    localparam int unsigned REG_W    = 8;       // every register is one byte wide
    localparam int unsigned IDX_W    = 8;       // register index width
    localparam int unsigned IDX_LSB  = 2;       // byte address is four times the index
    localparam int unsigned TERM_N   = 4;       // analog input pairs a, b, c, d

    // =====================================================================
    // register indices (byte address = index * 4)
    // =====================================================================
    localparam logic [IDX_W-1:0] IDX_GAIN   = 8'h7a;   // core_gain_adjust
    localparam logic [IDX_W-1:0] IDX_REF    = 8'h7c;   // reference_voltage_adjust
    localparam logic [IDX_W-1:0] IDX_TERM_A = 8'h7e;   // input_a_termination_adjust
    localparam logic [IDX_W-1:0] IDX_TERM_B = 8'h7f;   // input_b_termination_adjust
    localparam logic [IDX_W-1:0] IDX_TERM_C = 8'h80;   // input_c_termination_adjust
    localparam logic [IDX_W-1:0] IDX_TERM_D = 8'h81;   // input_d_termination_adjust
    localparam logic [IDX_W-1:0] IDX_OVL    = 8'h9a;   // swap_overlap_length
    localparam logic [IDX_W-1:0] IDX_STEER  = 8'h9b;   // steer_select_delay
    localparam logic [IDX_W-1:0] IDX_STAT   = 8'ha0;   // swap_status, read only
    // termination indices as one table, entry i belongs to input i
    localparam logic [TERM_N-1:0][IDX_W-1:0] IDX_TERM =
        {IDX_TERM_D, IDX_TERM_C, IDX_TERM_B, IDX_TERM_A};

    // =====================================================================
    // reset values
    // =====================================================================
    localparam logic [REG_W-1:0] RST_TRIM  = 8'h00;    // trims before fuse load
    localparam logic [REG_W-1:0] RST_OVL   = 8'h08;    // overlap length
    localparam logic [REG_W-1:0] RST_STEER = 8'h07;    // steering select delay

    // =====================================================================
    // field layout
    // =====================================================================
    localparam int unsigned REF_W   = 4;        // band-gap trim field 3:0
    localparam int unsigned DLY_W   = 5;        // overlap and steer fields 4:0
    localparam int unsigned CNT_W   = 7;        // holds 4 + 2*31 = 66
    localparam int unsigned SEL_W   = 2;        // steering select, one of four cores
    localparam logic [CNT_W-1:0] OVL_BASE = 7'h04;  // fixed part of the overlap
    localparam int unsigned OVL_SHIFT     = 1;      // times two for the field part
    // swap_status bit positions
    localparam int unsigned STAT_OVERLAP = 0;
    localparam int unsigned STAT_BUSY    = 1;
    localparam int unsigned STAT_LOADED  = 2;

endpackage : cvtrim_pkg

// *** design/cvtrim_swap_if.sv ***
// signals between the register bank and its two swap timing helpers
// assumes all parties run on the same clock as the bank
interface cvtrim_swap_if;
    import cvtrim_pkg::*;

    logic                start;     // one-cycle pulse: background swap begins
    logic [SEL_W-1:0]    sel_req;   // select wanted by the calibration engine
    logic [DLY_W-1:0]    ovl_len;   // overlap field value
    logic [DLY_W-1:0]    steer_dly; // steering delay field value
    logic                overlap;   // two cores sampling the same input
    logic                busy;      // swap in progress
    logic [SEL_W-1:0]    sel_out;   // select actually steering the encoders

    modport ctrl (output start, sel_req, ovl_len, steer_dly,
                  input  overlap, busy, sel_out);
    modport ovl  (input  start, ovl_len, output overlap, busy);
    modport mux  (input  start, busy, sel_req, steer_dly, output sel_out);
endinterface : cvtrim_swap_if

// *** design/cvtrim_overlap_timer.sv ***
// overlap window timer for a background core swap
// assumes start is a clean one-cycle pulse; a start during a swap restarts it
module cvtrim_overlap_timer
    import cvtrim_pkg::*;
(
    input  wire logic    mclk_i,    // core clock
    input  wire logic    nrst_i,    // synchronous reset, active low
    cvtrim_swap_if.ovl   swp        // swap timing signals
);

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic [CNT_W-1:0] cnt;      // cycles of overlap still to run
    } cvtrim_ovl_state_type;

    cvtrim_ovl_state_type st_r;     // registered state
    cvtrim_ovl_state_type st_nxt;   // next state

    // load 4 + 2*len on start, then count down to zero
    always_comb begin
        st_nxt = st_r;
        if (swp.start) begin
            st_nxt.cnt = OVL_BASE + (CNT_W'(swp.ovl_len) << OVL_SHIFT);
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 7'h01;
        end
    end

    // register the state
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // overlap lasts exactly the loaded count; it is the whole swap here
    assign swp.overlap = (st_r.cnt != '0);
    assign swp.busy    = (st_r.cnt != '0);

endmodule : cvtrim_overlap_timer

// *** design/cvtrim_sel_delay.sv ***
// steering select delay: holds back the select change during a swap
// assumes busy comes from the overlap timer and rises the cycle after start
module cvtrim_sel_delay
    import cvtrim_pkg::*;
(
    input  wire logic    mclk_i,    // core clock
    input  wire logic    nrst_i,    // synchronous reset, active low
    cvtrim_swap_if.mux   swp        // swap timing signals
);

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic             pend;     // a delayed select change is waiting
        logic [DLY_W-1:0] cnt;      // delay cycles left
        logic [SEL_W-1:0] hold;     // select captured at swap start
        logic [SEL_W-1:0] sel;      // select driven to the encoder muxes
    } cvtrim_mux_state_type;

    cvtrim_mux_state_type st_r;     // registered state
    cvtrim_mux_state_type st_nxt;   // next state

    // outside a swap the select follows at once; inside it waits
    always_comb begin
        st_nxt = st_r;
        if (swp.start) begin
            st_nxt.pend = 1'b1;
            st_nxt.cnt  = swp.steer_dly;
            st_nxt.hold = swp.sel_req;
        end else if (st_r.pend) begin
            // a swap that ends early must not strand the old select
            if (st_r.cnt == '0 || !swp.busy) begin
                st_nxt.pend = 1'b0;
                st_nxt.sel  = st_r.hold;
            end else begin
                st_nxt.cnt = st_r.cnt - 5'h01;
            end
        end else begin
            st_nxt.sel = swp.sel_req;           // no delay off-swap
        end
    end

    // register the state
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign swp.sel_out = st_r.sel;

endmodule : cvtrim_sel_delay

// *** design/cvtrim_regs.sv ***
// trim and swap delay register bank of a multi-channel data converter
// assumes an apb master on mclk_i and fuse values stable from reset release
// the calibration engine supplies swap_start_i and core_sel_i
//
// Implementation choice: the APB register port.

module cvtrim_regs
    import cvtrim_pkg::*;
(
    input  wire logic                                  mclk_i,
    input  wire logic                                  nrst_i,
    // apb slave
    input  wire logic                                  psel_i,
    input  wire logic                                  penable_i,
    input  wire logic                                  pwrite_i,
    input  wire logic [cvtrim_pkg::APB_AW-1:0]         paddr_i,
    input  wire logic [cvtrim_pkg::APB_DW-1:0]         pwdata_i,
    output logic      [cvtrim_pkg::APB_DW-1:0]         prdata_o,
    output logic                                       pready_o,
    output logic                                       pslverr_o,
    // factory fuse values
    input  wire logic [cvtrim_pkg::REG_W-1:0]          fuse_gain_i,
    input  wire logic [cvtrim_pkg::REG_W-1:0]          fuse_ref_i,
    input  wire logic [cvtrim_pkg::TERM_N-1:0][cvtrim_pkg::REG_W-1:0] fuse_term_i,
    // trims towards the analog section
    output logic      [cvtrim_pkg::REG_W-1:0]          gain_trim_o,
    output logic      [cvtrim_pkg::REF_W-1:0]          ref_trim_o,
    output logic      [cvtrim_pkg::TERM_N-1:0][cvtrim_pkg::REG_W-1:0] term_trim_o,
    // background swap control
    input  wire logic                                  swap_start_i,
    input  wire logic [cvtrim_pkg::SEL_W-1:0]          core_sel_i,
    output logic                                       overlap_active_o,
    output logic      [cvtrim_pkg::SEL_W-1:0]          steer_sel_o
);
    import cvtrim_pkg::*;

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic [REG_W-1:0]             gain;    // core_gain_adjust
        logic [REG_W-1:0]             refv;    // reference_voltage_adjust
        logic [TERM_N-1:0][REG_W-1:0] term;    // termination trims a..d
        logic [REG_W-1:0]             ovl;     // swap_overlap_length
        logic [REG_W-1:0]             steer;   // steer_select_delay
        logic                         loaded;  // fuse values have been taken
        logic [APB_DW-1:0]            rdata;   // read data for the access phase
        logic                         slverr;  // error answer for the access phase
    } cvtrim_top_state_type;

    cvtrim_top_state_type st_r;                // registered state
    cvtrim_top_state_type st_nxt;              // next state

    // =====================================================================
    // address decode
    // =====================================================================
    logic [IDX_W-1:0]  idx;                    // word index of the access
    logic              aligned;                // low bits zero, high bits in range
    logic [TERM_N-1:0] term_hit;               // one per termination register
    logic              setup_ph;               // apb setup cycle
    logic              wr_acc;                 // apb write taking effect now

    assign idx      = paddr_i[IDX_LSB +: IDX_W];
    assign aligned  = (paddr_i[IDX_LSB-1:0] == '0) &&
                      (paddr_i[APB_AW-1:IDX_LSB+IDX_W] == '0);
    assign setup_ph = psel_i & ~penable_i;
    assign wr_acc   = psel_i & penable_i & pwrite_i;

    // per-input termination decode and trim output
    genvar gi;
    generate
        for (gi = 0; gi < TERM_N; gi++) begin : g_term
            assign term_hit[gi]    = aligned & (idx == IDX_TERM[gi]);
            assign term_trim_o[gi] = st_r.term[gi];    // only input gi
        end
    endgenerate

    // =====================================================================
    // swap helpers
    // =====================================================================
    cvtrim_swap_if swp ();                     // shared swap timing bundle

    assign swp.start     = swap_start_i;
    assign swp.sel_req   = core_sel_i;
    // reserved bits 7:5 are stored but never reach the timers
    assign swp.ovl_len   = st_r.ovl[DLY_W-1:0];
    assign swp.steer_dly = st_r.steer[DLY_W-1:0];

    // overlap window length per swap
    cvtrim_overlap_timer u_ovl (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .swp    (swp.ovl)
    );

    // select steering with swap-only delay
    cvtrim_sel_delay u_mux (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .swp    (swp.mux)
    );

    // =====================================================================
    // register file and apb
    // =====================================================================
    // reads are captured in setup, so prdata comes from a flop and
    // the slave still answers with zero wait states
    always_comb begin
        logic [REG_W-1:0] rd;                  // byte selected for reading
        logic             hit;                 // address maps to a register
        rd     = '0;
        hit    = 1'b1;
        st_nxt = st_r;

        // read mux, in address order
        if (!aligned) begin
            hit = 1'b0;                        // misaligned or out-of-range address
        end else if (idx == IDX_GAIN) begin
            rd = st_r.gain;
        end else if (idx == IDX_REF) begin
            rd = st_r.refv;                    // reserved 7:4 read as stored
        end else if (|term_hit) begin
            for (int i = 0; i < TERM_N; i++) begin
                if (term_hit[i]) begin
                    rd = st_r.term[i];
                end
            end
        end else if (idx == IDX_OVL) begin
            rd = st_r.ovl;
        end else if (idx == IDX_STEER) begin
            rd = st_r.steer;
        end else if (idx == IDX_STAT) begin
            rd[STAT_OVERLAP] = swp.overlap;
            rd[STAT_BUSY]    = swp.busy;
            rd[STAT_LOADED]  = st_r.loaded;
        end else begin
            hit = 1'b0;                        // unmapped index
        end

        // setup cycle: prepare the answer for the access phase
        if (setup_ph) begin
            st_nxt.rdata  = {{(APB_DW-REG_W){1'b0}}, pwrite_i ? 8'h00 : rd};
            st_nxt.slverr = ~hit;
        end

        // first cycle after reset release: take the factory trims
        if (!st_r.loaded) begin
            st_nxt.loaded = 1'b1;
            st_nxt.gain   = fuse_gain_i;
            st_nxt.refv   = fuse_ref_i;
            st_nxt.term   = fuse_term_i;
        end else if (wr_acc && hit) begin
            // software adjusts trims after the fuse load
            // all bits stored; software keeps reserved bits at default
            if (idx == IDX_GAIN) begin
                st_nxt.gain = pwdata_i[REG_W-1:0];
            end else if (idx == IDX_REF) begin
                st_nxt.refv = pwdata_i[REG_W-1:0];
            end else if (|term_hit) begin
                for (int i = 0; i < TERM_N; i++) begin
                    if (term_hit[i]) begin
                        st_nxt.term[i] = pwdata_i[REG_W-1:0];
                    end
                end
            end else if (idx == IDX_OVL) begin
                // any value 0..31 accepted; no guard against a running
                // calibration, software must stop it first
                st_nxt.ovl = pwdata_i[REG_W-1:0];
            end else if (idx == IDX_STEER) begin
                st_nxt.steer = pwdata_i[REG_W-1:0];
            end else begin
                st_nxt.steer = st_r.steer;             // status is read only
            end
        end
    end

    // register the state
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            st_r        <= '0;
            st_r.gain   <= RST_TRIM;
            st_r.refv   <= RST_TRIM;
            st_r.term   <= {TERM_N{RST_TRIM}};
            st_r.ovl    <= RST_OVL;
            st_r.steer  <= RST_STEER;
            st_r.loaded <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign pready_o         = 1'b1;                    // never stretches access
    assign prdata_o         = st_r.rdata;
    assign pslverr_o        = st_r.slverr;
    assign gain_trim_o      = st_r.gain;               // one value, all cores
    assign ref_trim_o       = st_r.refv[REF_W-1:0];
    assign overlap_active_o = swp.overlap;
    assign steer_sel_o      = swp.sel_out;

endmodule : cvtrim_regs

// *** dv/cvtrim_regs_chk.sv ***
// port-level assertions for the trim and swap delay register bank
// assumes it is bound to cvtrim_regs and sees its ports only
module cvtrim_regs_chk (
    input wire logic                                  mclk_i,
    input wire logic                                  nrst_i,
    input wire logic                                  psel_i,
    input wire logic                                  penable_i,
    input wire logic                                  pwrite_i,
    input wire logic [cvtrim_pkg::APB_AW-1:0]         paddr_i,
    input wire logic [cvtrim_pkg::APB_DW-1:0]         pwdata_i,
    input wire logic [cvtrim_pkg::APB_DW-1:0]         prdata_o,
    input wire logic [cvtrim_pkg::REG_W-1:0]          gain_trim_o,
    input wire logic [cvtrim_pkg::REF_W-1:0]          ref_trim_o,
    input wire logic [cvtrim_pkg::TERM_N-1:0][cvtrim_pkg::REG_W-1:0] term_trim_o,
    input wire logic                                  swap_start_i,
    input wire logic [cvtrim_pkg::SEL_W-1:0]          core_sel_i,
    input wire logic                                  overlap_active_o,
    input wire logic [cvtrim_pkg::SEL_W-1:0]          steer_sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import cvtrim_pkg::*;
    // =====================================================================
    // helpers
    // =====================================================================
    localparam logic [11:0] A_GAIN = {2'b00, IDX_GAIN, 2'b00};    // gain byte address
    localparam logic [11:0] A_REF  = {2'b00, IDX_REF, 2'b00};     // reference byte address
    localparam logic [11:0] A_TA   = {2'b00, IDX_TERM_A, 2'b00};  // input a byte address
    localparam logic [11:0] A_OVL  = {2'b00, IDX_OVL, 2'b00};     // overlap byte address
    logic [6:0] run_r;   // overlap cycles since the last start
    logic [4:0] ovl_w_r; // overlap field as last written
    // mirror of the overlap field, taken from bus writes
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ovl_w_r <= RST_OVL[4:0];
        end else if (psel_i && penable_i && pwrite_i && paddr_i == A_OVL) begin
            ovl_w_r <= pwdata_i[4:0];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // counter restarts on every start, so a restarted swap is measured afresh
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || swap_start_i) begin
            run_r <= 7'h00;
        end else if (overlap_active_o) begin
            run_r <= run_r + 7'h01;
        end
    end
    // =====================================================================
    // assertions
    // =====================================================================
    AST_RDATA_HI: assert property (prdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_GAIN_WR: assert property (psel_i && penable_i && pwrite_i && paddr_i == A_GAIN
        && $past(nrst_i) |=> gain_trim_o == $past(pwdata_i[7:0]))
        else $error("gain trim output missed a write");
    AST_REF_WR: assert property (psel_i && penable_i && pwrite_i && paddr_i == A_REF
        && $past(nrst_i) |=> ref_trim_o == $past(pwdata_i[3:0]))
        else $error("band-gap trim output missed a write");
    AST_TERM_WR: assert property (psel_i && penable_i && pwrite_i && paddr_i == A_TA
        && $past(nrst_i) |=> term_trim_o[0] == $past(pwdata_i[7:0]) && $stable(term_trim_o[3:1]))
        else $error("input a trim write wrong or leaked");
    AST_OVL_GO: assert property (swap_start_i |=> overlap_active_o)
        else $error("overlap did not follow a start");
    AST_OVL_CAUSE: assert property ($rose(overlap_active_o) |-> $past(swap_start_i))
        else $error("overlap rose without a start");
    AST_OVL_MIN: assert property ($rose(overlap_active_o) |-> overlap_active_o [*4])
        else $error("overlap shorter than four cycles");
    AST_OVL_LEN: assert property ($fell(overlap_active_o) |->
        run_r == 7'd4 + {1'b0, ovl_w_r, 1'b0})
        else $error("overlap length not four plus twice field");
    AST_STEER_IDLE: assert property ((!overlap_active_o && !swap_start_i) [*3]
        |=> steer_sel_o == $past(core_sel_i))
        else $error("steer select delayed outside a swap");
    // main scenarios seen
    COV_OVL: cover property ($fell(overlap_active_o));
    COV_STEER: cover property (overlap_active_o && !$stable(steer_sel_o));
    COV_WR: cover property (psel_i && penable_i && pwrite_i);
endmodule : cvtrim_regs_chk

// *** dv/tb.sv ***
// self-checking bench for the trim and swap delay register bank
// assumes the bank answers apb with pready as the note states
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cvtrim_pkg::*;
    // =====================================================================
    // stimulus and observed signals
    // =====================================================================
    logic mclk_i = 1'b0, nrst_i = 1'b0;                        // clock, reset
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;    // apb control
    logic [11:0] paddr_i = 12'h0;                              // apb address
    logic [31:0] pwdata_i = 32'h0, prdata_o;                   // apb data
    logic pready_o, pslverr_o, overlap_active_o;               // answers
    logic swap_start_i = 1'b0;                                 // swap pulse
    logic [1:0] core_sel_i = 2'h0, steer_sel_o;                // steering
    logic [7:0] gain_trim_o;                                   // gain trim out
    logic [3:0] ref_trim_o;                                    // band-gap out
    logic [3:0][7:0] term_trim_o;                              // termination out
    logic [3:0][7:0] fuse_term = {8'h44, 8'h33, 8'h22, 8'h11}; // distinct per input
    int fails = 0, n_checks = 0;                               // tallies
    localparam logic [7:0] IDXS [8] = '{IDX_GAIN, IDX_REF, IDX_TERM_A, IDX_TERM_B,
        IDX_TERM_C, IDX_TERM_D, IDX_OVL, IDX_STEER};
    // reserved bits written as default zero
    localparam logic [7:0] WV [8] = '{8'ha5, 8'h0a, 8'h81, 8'h7e, 8'hc4, 8'h3b, 8'h1f, 8'h00};
    always #25 mclk_i = ~mclk_i;  // 20 mhz
    cvtrim_regs cvtrim_regs_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .fuse_gain_i(8'h5a), .fuse_ref_i(8'h0c), .fuse_term_i(fuse_term),
        .gain_trim_o(gain_trim_o), .ref_trim_o(ref_trim_o), .term_trim_o(term_trim_o),
        .swap_start_i(swap_start_i), .core_sel_i(core_sel_i),
        .overlap_active_o(overlap_active_o), .steer_sel_o(steer_sel_o));
    // =====================================================================
    // shared tasks
    // =====================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int t;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= {24'h0, wd};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk_i);
            t++;
        end while (pready_o !== 1'b1 && t < 50);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (t >= 50) fails++;
    endtask : apb
    // pulse a start with a new select; count overlap cycles and select lag
    task automatic swap(input logic [1:0] sel, output int k, output int n);
        int c;
        k = -1;
        n = 0;
        @(posedge mclk_i);
        swap_start_i <= 1'b1;
        core_sel_i <= sel;
        @(posedge mclk_i);
        swap_start_i <= 1'b0;
        for (c = 0; c < 80; c++) begin
            #1;
            if (overlap_active_o === 1'b1) n++;
            if (k < 0 && steer_sel_o === sel) k = c;
            @(posedge mclk_i);
        end
    endtask : swap
    // =====================================================================
    // scenarios
    // =====================================================================
    task automatic t_reset();
        logic [31:0] v;
        logic e;
        logic [7:0] rv [8];
        rv = '{8'h5a, 8'h0c, 8'h11, 8'h22, 8'h33, 8'h44, RST_OVL, RST_STEER};
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, IDXS[i], 8'h00, v, e);
            chk(v, {24'h0, rv[i]}, "reset readback");
            chk(e, 1'b0, "mapped access error");
        end
        chk(gain_trim_o, 8'h5a, "gain after fuse load");
        chk(ref_trim_o, 4'hc, "band-gap after fuse load");
        chk(term_trim_o, fuse_term, "terminations after fuse load");
    endtask : t_reset
    task automatic t_write();
        logic [31:0] v;
        logic e;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, IDXS[i], WV[i], v, e);
            if (i == 2) begin
                #1;
                chk(term_trim_o, {8'h44, 8'h33, 8'h22, 8'h81}, "term a alone");
            end
            apb(1'b0, IDXS[i], 8'h00, v, e);
            chk(v, {24'h0, WV[i]}, "written readback");
        end
        chk(gain_trim_o, 8'ha5, "gain written");
        chk(ref_trim_o, 4'ha, "band-gap written");
        chk(term_trim_o, {8'h3b, 8'hc4, 8'h7e, 8'h81}, "terminations written");
    endtask : t_write
    task automatic t_unmapped();
        logic [31:0] v;
        logic e;
        apb(1'b0, 8'h90, 8'h00, v, e);
        chk({v[30:0], e}, 32'h1, "unmapped read");
        apb(1'b1, 8'h90, 8'h55, v, e);
        chk(e, 1'b1, "unmapped write");
        apb(1'b0, IDX_STAT, 8'h00, v, e);
        chk(v, 32'h4, "status idle and loaded");
    endtask : t_unmapped
    task automatic t_swap();
        logic [31:0] v;
        logic e;
        int k, n;
        int nv [3] = '{0, 7, 31};
        apb(1'b1, IDX_STEER, 8'h02, v, e); // inside the valid window
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, IDX_OVL, nv[i][7:0], v, e); // only between swaps
            swap(2'(i + 1), k, n);
            chk(n, 4 + 2 * nv[i], "overlap length");
            chk(k, 3, "steer delay in swap");
        end
        @(posedge mclk_i);
        core_sel_i <= 2'h0;
        @(posedge mclk_i);
        #1;
        chk(steer_sel_o, 2'h0, "steer outside swap");
    endtask : t_swap
    // =====================================================================
    // sequence, watchdog, verdict
    // =====================================================================
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (20) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        t_reset();
        t_write();
        t_unmapped();
        t_swap();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        fails++;
        finish_test();
    end
endmodule : tb
bind cvtrim_regs cvtrim_regs_chk cvtrim_regs_chk_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .gain_trim_o(gain_trim_o),
    .ref_trim_o(ref_trim_o), .term_trim_o(term_trim_o), .swap_start_i(swap_start_i),
    .core_sel_i(core_sel_i), .overlap_active_o(overlap_active_o), .steer_sel_o(steer_sel_o));
